// ===== verilog/synth_function_clock_regs.sv
// Function and clock register bank of a fractional-N synthesizer.
// Assumes synchronous pin inputs, a one-cycle reference tick, a one-cycle PFD
// tick and an upstream PFD pulse width measurement.

// Operation
// (RQ1) Control pattern 011 loads function register.
// (RQ2) Host writes reserved zeros, bit seventeen one.
// (RQ3) Bleed level bits 24-22, enabled by 21.
// (RQ4) Bit 16 selects loss-of-lock indication mode.
// (RQ5) Bit 15 delays integer load to align.
// (RQ6) Bit 14 clear resets modulator on writes.
// (RQ7) Bits 11-10 select ramp waveform type.
// (RQ8) Bit 9 enables PSK, bit 8 FSK.
// (RQ9) Every 32nd pulse measured, five narrow lock.
// (RQ10) Lock holds until wide pulse, write, powerdown.
// (RQ11) Bit 6 sets phase detector polarity.
// (RQ12) Power-down keeps registers, stops counters, pump.
// (RQ13) Bit 4 three-states the charge pump.
// (RQ14) Bit 3 holds RF counters in reset.
// (RQ15) Control pattern 100 loads clock register.
// (RQ16) Bit 31 syncs load enable to reference.
// (RQ17) Modulator mode 01110 gives integer-N, features off.
// (RQ18) Host zeros fraction, then pulses counter reset.
// (RQ19) Bits 25-21 select ramp status output.
// (RQ20) Host sets mux select ones for readback.
// (RQ21) Bits 20-19 select divider mode, 00 none.
// (RQ22) Bits 18-7 load second timer divider.
// (RQ23) Ramp mode 11 is single ramp burst.
// (RQ24) Int/frac bits 30-27 select test mux source.
// (RQ25) Word shifted MSB first, latched on load enable.
module synth_function_clock_regs
(
   input  wire logic                 clk_sys,
   input  wire logic                 reset,
   input  wire logic                 ser_clk_pin,
   input  wire logic                 ser_data_pin,
   input  wire logic                 load_enable_pin,
   input  wire logic                 ref_tick,
   input  wire logic                 pfd_tick,
   input  sfcr_pkg::sfcr_pulse_t     pfd_pulse,
   output sfcr_pkg::sfcr_func_t      function_control,
   output sfcr_pkg::sfcr_clock_t     clock_ramp_config,
   output logic [31:0]               loaded_word,
   output logic                      loaded_word_strobe,
   output logic [2:0]                bleed_current_level,
   output logic                      bleed_active,
   output logic                      loss_of_lock_mode,
   output logic                      int_load_strobe,
   output logic                      frac_load_strobe,
   output logic                      modulator_reset,
   output logic [1:0]                ramp_mode,
   output logic                      ramp_enable,
   output logic                      single_ramp_burst,
   output logic                      psk_enable,
   output logic                      fsk_enable,
   output logic                      phase_adjust_enable,
   output logic                      lock_detect,
   output logic                      pd_polarity,
   output logic                      power_down,
   output logic                      cp_three_state,
   output logic                      rf_counter_reset,
   output logic                      rf_counter_load,
   output logic                      modulator_disable,
   output logic [4:0]                ramp_status,
   output logic                      ramp_divider_select,
   output logic                      fast_lock_divider_select,
   output logic [11:0]               second_timer_divider,
   output logic [11:0]               second_timer_divider_alt,
   output logic [3:0]                test_mux_select
);
   import sfcr_pkg::*;

   // ==========================================================================
   // Helpers
   // ==========================================================================
   function automatic logic targets(input logic [31:0] word, input logic [2:0] code);
      targets = (word[2:0] == code);
   endfunction : targets

   // ==========================================================================
   // Serial port
   // ==========================================================================
   logic [31:0] shift_word;
   logic        ld_rise;

   sfcr_shifter u_shifter
   (
      .clk_sys         (clk_sys),
      .reset           (reset),
      .ser_clk_pin     (ser_clk_pin),
      .ser_data_pin    (ser_data_pin),
      .load_enable_pin (load_enable_pin),
      .shift_q         (shift_word),
      .ld_rise         (ld_rise)
   );

   // ==========================================================================
   // Latch timing, optionally aligned to the reference
   // ==========================================================================
   sfcr_func_t  func_q;
   sfcr_clock_t clock_q;
   logic [31:0] held_word_q;
   logic        sync_pending_q;
   logic [11:0] div_main_q;
   logic [11:0] div_alt_q;
   logic [3:0]  mux_sel_q;
   logic [31:0] word_out_q;
   logic        word_strobe_q;

   // The word is captured at the load enable edge so that bits shifted in while
   // waiting for the reference tick do not corrupt the pending word.
   wire         sync_mode   = clock_q.latch_sync_select;
   wire         commit_now  = ld_rise & ~sync_mode;
   wire         commit_sync = sync_pending_q & ref_tick; // RQ16
   wire         commit      = commit_now | commit_sync;
   wire [31:0]  commit_word = commit_sync ? held_word_q : shift_word;

   wire         hit_func    = commit & targets(commit_word, CTRL_FUNCTION); // RQ1
   wire         hit_clock   = commit & targets(commit_word, CTRL_CLOCK); // RQ15
   wire         hit_intfrac = commit & targets(commit_word, CTRL_INT_FRAC);
   wire         new_clk_sel = commit_word[6];

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         held_word_q    <= 32'h0000_0000;
         sync_pending_q <= 1'b0;
      end
      else
      begin
         if (ld_rise & sync_mode)
         begin
            held_word_q <= shift_word;
         end
         if (ld_rise & sync_mode)
         begin
            sync_pending_q <= 1'b1; // RQ16
         end
         else if (commit_sync)
         begin
            sync_pending_q <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Register bank, kept through power-down
   // ==========================================================================
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         func_q        <= FUNC_RESET;
         clock_q       <= CLOCK_RESET;
         div_main_q    <= DIV_RESET;
         div_alt_q     <= DIV_RESET;
         mux_sel_q     <= 4'h0;
         word_out_q    <= 32'h0000_0000;
         word_strobe_q <= 1'b0;
      end
      else
      begin
         word_strobe_q <= commit;
         if (commit)
         begin
            word_out_q <= commit_word; // RQ25
         end
         if (hit_func)
         begin
            func_q <= commit_word; // RQ12
         end
         if (hit_clock)
         begin
            clock_q <= commit_word;
         end
         if (hit_clock & ~new_clk_sel)
         begin
            div_main_q <= commit_word[18:7]; // RQ22
         end
         if (hit_clock & new_clk_sel)
         begin
            div_alt_q <= commit_word[18:7]; // RQ22
         end
         if (hit_intfrac)
         begin
            mux_sel_q <= commit_word[INTFRAC_MUX_LSB +: 4]; // RQ24
         end
      end
   end

   // ==========================================================================
   // Integer/fraction load alignment and modulator reset
   // ==========================================================================
   logic [2:0] nsel_cnt_q;
   logic       nsel_wait_q;
   logic       int_load_q;
   logic       frac_load_q;
   logic       mod_reset_q;

   wire nsel_done = nsel_wait_q & pfd_tick & (nsel_cnt_q == 3'(NSEL_DELAY_PFD - 1));

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         nsel_cnt_q  <= 3'h0;
         nsel_wait_q <= 1'b0;
         int_load_q  <= 1'b0;
         frac_load_q <= 1'b0;
         mod_reset_q <= 1'b0;
      end
      else
      begin
         frac_load_q <= hit_intfrac;
         mod_reset_q <= hit_intfrac & ~func_q.sd_reset_inhibit; // RQ6
         int_load_q  <= (hit_intfrac & ~func_q.int_load_align) | nsel_done; // RQ5
         if (hit_intfrac & func_q.int_load_align)
         begin
            nsel_wait_q <= 1'b1; // RQ5
            nsel_cnt_q  <= 3'h0;
         end
         else if (nsel_done)
         begin
            nsel_wait_q <= 1'b0;
         end
         else if (nsel_wait_q & pfd_tick)
         begin
            nsel_cnt_q <= nsel_cnt_q + 3'h1;
         end
      end
   end

   // ==========================================================================
   // Lock detect
   // ==========================================================================
   wire lock_clear = hit_intfrac | func_q.power_down; // RQ10

   sfcr_lock_detect u_lock
   (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .pulse     (pfd_pulse),
      .precision (func_q.lock_precision_select),
      .clear     (lock_clear),
      .lock_q    (lock_detect)
   );

   // ==========================================================================
   // Decoded controls
   // ==========================================================================
   wire int_mode = (clock_q.modulator_mode == MOD_MODE_INTEGER); // RQ17

   assign function_control         = func_q;
   assign clock_ramp_config        = clock_q;
   assign loaded_word              = word_out_q;
   assign loaded_word_strobe       = word_strobe_q;
   assign bleed_current_level      = func_q.bleed_current_level; // RQ3
   assign bleed_active             = func_q.bleed_enable; // RQ3
   assign loss_of_lock_mode        = func_q.loss_of_lock_mode; // RQ4
   assign int_load_strobe          = int_load_q;
   assign frac_load_strobe         = frac_load_q;
   assign modulator_reset          = mod_reset_q;
   assign ramp_mode                = func_q.ramp_mode; // RQ7
   assign ramp_enable              = ~int_mode; // RQ17
   assign single_ramp_burst        = (func_q.ramp_mode == RAMP_MODE_SINGLE_BURST); // RQ23
   assign psk_enable               = func_q.psk_enable & ~int_mode; // RQ8
   assign fsk_enable               = func_q.fsk_enable & ~int_mode; // RQ8
   assign phase_adjust_enable      = ~int_mode; // RQ17
   assign pd_polarity              = func_q.pd_polarity; // RQ11
   assign power_down               = func_q.power_down; // RQ12
   assign cp_three_state           = func_q.cp_three_state | func_q.power_down; // RQ13
   assign rf_counter_reset         = func_q.counter_reset; // RQ14
   assign rf_counter_load          = func_q.power_down; // RQ12
   assign modulator_disable        = int_mode; // RQ17
   assign ramp_status              = clock_q.ramp_status; // RQ19
   assign ramp_divider_select      = (clock_q.clock_divider_mode != CLKDIV_MODE_NONE) & ~clock_q.clock_divider_mode[1]; // RQ21
   assign fast_lock_divider_select = clock_q.clock_divider_mode[1]; // RQ21
   assign second_timer_divider     = div_main_q;
   assign second_timer_divider_alt = div_alt_q;
   assign test_mux_select          = mux_sel_q; // RQ24

endmodule : synth_function_clock_regs

// ===== pkg/sfcr_pkg.sv
// Constants, field layouts and types of the function and clock register bank.
// Assumes a single 50 MHz system clock and a synchronous active-high reset.
package sfcr_pkg;

   // ==========================================================================
   // Clock and timing
   // ==========================================================================
   localparam int unsigned CLK_SYS_HZ     = 50_000_000;
   localparam int unsigned NSEL_DELAY_PFD = 4;

   // ==========================================================================
   // Control bit patterns in the low three bits of a word
   // ==========================================================================
   localparam logic [2:0] CTRL_INT_FRAC = 3'h0;
   localparam logic [2:0] CTRL_FUNCTION = 3'h3;
   localparam logic [2:0] CTRL_CLOCK    = 3'h4;
   localparam int unsigned WORD_BITS    = 32;

   // ==========================================================================
   // Field positions and encodings
   // ==========================================================================
   localparam int unsigned INTFRAC_MUX_LSB        = 27;
   localparam logic [4:0]  MOD_MODE_NORMAL        = 5'h00;
   localparam logic [4:0]  MOD_MODE_INTEGER       = 5'h0E;
   localparam logic [1:0]  RAMP_MODE_SINGLE_BURST = 2'h3;
   localparam logic [1:0]  CLKDIV_MODE_NONE       = 2'h0;

   // ==========================================================================
   // Lock detector
   // ==========================================================================
   localparam int unsigned LD_SAMPLE_EVERY = 32;
   localparam int unsigned LD_GOOD_NEEDED  = 5;
   localparam logic [7:0]  LD_COARSE_NS    = 8'h0E;
   localparam logic [7:0]  LD_FINE_NS      = 8'h06;
   localparam logic [7:0]  LD_UNLOCK_NS    = 8'h16;

   // ==========================================================================
   // Register layouts
   // ==========================================================================
   typedef struct packed {
      logic [6:0] rsvd_hi;
      logic [2:0] bleed_current_level;
      logic       bleed_enable;
      logic [2:0] rsvd_mid;
      logic       rsvd_one;
      logic       loss_of_lock_mode;
      logic       int_load_align;
      logic       sd_reset_inhibit;
      logic [1:0] rsvd_lo;
      logic [1:0] ramp_mode;
      logic       psk_enable;
      logic       fsk_enable;
      logic       lock_precision_select;
      logic       pd_polarity;
      logic       power_down;
      logic       cp_three_state;
      logic       counter_reset;
      logic [2:0] ctrl;
   } sfcr_func_t;

   typedef struct packed {
      logic        latch_sync_select;
      logic [4:0]  modulator_mode;
      logic [4:0]  ramp_status;
      logic [1:0]  clock_divider_mode;
      logic [11:0] second_timer_divider;
      logic        clk_div_select;
      logic [2:0]  rsvd;
      logic [2:0]  ctrl;
   } sfcr_clock_t;

   typedef struct packed {
      logic       strobe;
      logic [7:0] width_ns;
   } sfcr_pulse_t;

   localparam logic [31:0] FUNC_RESET  = 32'h0002_0003;
   localparam logic [31:0] CLOCK_RESET = 32'h0000_0004;
   localparam logic [11:0] DIV_RESET   = 12'h000;

endpackage : sfcr_pkg

// ===== verilog/sfcr_shifter.sv
// Serial input shift register of the three-wire programming port.
// Assumes pin inputs already synchronous to clk_sys.
module sfcr_shifter
(
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        ser_clk_pin,
   input  wire logic        ser_data_pin,
   input  wire logic        load_enable_pin,
   output logic [31:0]      shift_q,
   output logic             ld_rise
);
   import sfcr_pkg::*;

   logic ser_clk_prev_q;
   logic ld_prev_q;
   wire  ser_clk_rise = ser_clk_pin & ~ser_clk_prev_q;

   assign ld_rise = load_enable_pin & ~ld_prev_q;

   // ==========================================================================
   // Shift, most significant bit first
   // ==========================================================================
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         ser_clk_prev_q <= 1'b0;
         ld_prev_q      <= 1'b0;
         shift_q        <= 32'h0000_0000;
      end
      else
      begin
         ser_clk_prev_q <= ser_clk_pin;
         ld_prev_q      <= load_enable_pin;
         if (ser_clk_rise)
         begin
            shift_q <= {shift_q[30:0], ser_data_pin}; // RQ25
         end
      end
   end

endmodule : sfcr_shifter

// ===== verilog/sfcr_lock_detect.sv
// Digital lock detector working on measured PFD pulse widths.
// Assumes an upstream timer reports each combined up/down pulse width in ns.
module sfcr_lock_detect
(
   input  wire logic                 clk_sys,
   input  wire logic                 reset,
   input  sfcr_pkg::sfcr_pulse_t     pulse,
   input  wire logic                 precision,
   input  wire logic                 clear,
   output logic                      lock_q
);
   import sfcr_pkg::*;

   logic [4:0] pulse_cnt_q;
   logic [2:0] good_cnt_q;

   wire       measure  = pulse.strobe & (pulse_cnt_q == 5'(LD_SAMPLE_EVERY - 1)); // RQ9
   wire [7:0] limit_ns = precision ? LD_FINE_NS : LD_COARSE_NS;
   wire       narrow   = pulse.width_ns < limit_ns;
   wire       wide     = pulse.width_ns > LD_UNLOCK_NS;
   wire       reach    = narrow & (good_cnt_q == 3'(LD_GOOD_NEEDED - 1));

   always_ff @(posedge clk_sys)
   begin
      if (reset | clear)
      begin
         pulse_cnt_q <= 5'h00;
         good_cnt_q  <= 3'h0;
         lock_q      <= 1'b0; // RQ10
      end
      else if (pulse.strobe)
      begin
         pulse_cnt_q <= pulse_cnt_q + 5'h01;
         if (measure)
         begin
            good_cnt_q <= narrow ? (reach ? good_cnt_q : good_cnt_q + 3'h1) : 3'h0; // RQ9
            if (wide)
            begin
               lock_q <= 1'b0; // RQ10
            end
            else if (reach)
            begin
               lock_q <= 1'b1; // RQ9
            end
         end
      end
   end

endmodule : sfcr_lock_detect

// ===== dv/sfcr_host_model.sv
// Host side of the three-wire programming port of the register bank.
// Assumes the bench calls send from one process, after reset is released.
module sfcr_host_model
(
   input  wire logic clk_sys,
   output logic      ser_clk_pin,
   output logic      ser_data_pin,
   output logic      load_enable_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================
   // Idle levels
   // ==========================
   initial
   begin
      ser_clk_pin     = 1'b0;
      ser_data_pin    = 1'b1;
      load_enable_pin = 1'b0;
   end

   // ==========================
   // Word transfer
   // ==========================
   // The clock stands low between frames and data shows the inverse of the last bit.
   task automatic send(input logic [31:0] w);
      for (int i = 31; i >= 0; i--)
      begin
         @(negedge clk_sys);
         ser_clk_pin  = 1'b0;
         ser_data_pin = w[i];
         @(negedge clk_sys);
         ser_clk_pin = 1'b1;
      end
      @(negedge clk_sys);
      ser_clk_pin  = 1'b0;
      ser_data_pin = ~w[0];
      @(negedge clk_sys);
      load_enable_pin = 1'b1;
      @(negedge clk_sys);
      load_enable_pin = 1'b0;
   endtask : send
endmodule : sfcr_host_model

// ===== dv/sfcr_assertions.sv
// Concurrent checks on the ports of the register bank.
// Assumes one clock domain and the synchronous active-high reset.
module sfcr_checker
(
   input wire logic            clk_sys,
   input wire logic            reset,
   input sfcr_pkg::sfcr_func_t  function_control,
   input sfcr_pkg::sfcr_clock_t clock_ramp_config,
   input wire logic [31:0]     loaded_word,
   input wire logic            loaded_word_strobe,
   input wire logic [2:0]      bleed_current_level,
   input wire logic            bleed_active,
   input wire logic            loss_of_lock_mode,
   input wire logic            frac_load_strobe,
   input wire logic            modulator_reset,
   input wire logic [1:0]      ramp_mode,
   input wire logic            ramp_enable,
   input wire logic            single_ramp_burst,
   input wire logic            psk_enable,
   input wire logic            fsk_enable,
   input wire logic            phase_adjust_enable,
   input wire logic            lock_detect,
   input wire logic            pd_polarity,
   input wire logic            cp_three_state,
   input wire logic            rf_counter_reset,
   input wire logic            rf_counter_load,
   input wire logic            modulator_disable
);
   timeunit 1ns;
   timeprecision 1ps;
   import sfcr_pkg::*;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   // ==========================
   // Loading
   // ==========================
   strobe_pulse_a: assert property (loaded_word_strobe |=> !loaded_word_strobe)
      else $error("strobe too long");
   func_load_a: assert property (!$stable(function_control) |->
      (function_control == loaded_word && loaded_word[2:0] == CTRL_FUNCTION) && loaded_word_strobe)
      else $error("function load wrong");
   clock_load_a: assert property (!$stable(clock_ramp_config) |->
      (clock_ramp_config == loaded_word && loaded_word[2:0] == CTRL_CLOCK) && loaded_word_strobe)
      else $error("clock load wrong");

   // ==========================
   // Field outputs
   // ==========================
   field_map_a: assert property (bleed_current_level == function_control.bleed_current_level &&
      bleed_active == function_control.bleed_enable && loss_of_lock_mode == function_control.loss_of_lock_mode
      && pd_polarity == function_control.pd_polarity) else $error("function field output wrong");
   ramp_fields_a: assert property (ramp_mode == function_control.ramp_mode &&
      single_ramp_burst == (function_control.ramp_mode == RAMP_MODE_SINGLE_BURST)) else $error("ramp mode wrong");
   integer_mode_a: assert property ((clock_ramp_config.modulator_mode == MOD_MODE_INTEGER) |->
      modulator_disable && !(ramp_enable || psk_enable || fsk_enable || phase_adjust_enable))
      else $error("integer mode wrong");
   keying_a: assert property (!modulator_disable |-> psk_enable == function_control.psk_enable &&
      fsk_enable == function_control.fsk_enable) else $error("keying enable wrong");
   pump_state_a: assert property (cp_three_state == (function_control.cp_three_state ||
      function_control.power_down) && rf_counter_reset == function_control.counter_reset &&
      rf_counter_load == function_control.power_down) else $error("pump or counter state wrong");
   lock_clear_a: assert property (function_control.power_down |=> !lock_detect)
      else $error("lock held in power-down");
   sd_reset_a: assert property (modulator_reset == (frac_load_strobe && !function_control.sd_reset_inhibit))
      else $error("modulator reset wrong");
endmodule : sfcr_checker

bind synth_function_clock_regs sfcr_checker u_chk (.clk_sys, .reset, .function_control, .clock_ramp_config,
   .loaded_word, .loaded_word_strobe, .bleed_current_level, .bleed_active, .loss_of_lock_mode, .frac_load_strobe,
   .modulator_reset, .ramp_mode, .ramp_enable, .single_ramp_burst, .psk_enable, .fsk_enable, .phase_adjust_enable,
   .lock_detect, .pd_polarity, .cp_three_state, .rf_counter_reset, .rf_counter_load, .modulator_disable);

// ===== dv/synth_function_clock_regs_test.sv
// Self-checking bench of the function and clock register bank.
// Assumes the package, the host model and the checker are compiled before it.
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module synth_function_clock_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   import sfcr_pkg::*;

   localparam logic [31:0] FUNC_A = 32'h0163_0F5B, FUNC_B = 32'h0163_CFC3, FUNC_PD = 32'h0163_CFE3;
   localparam logic [31:0] CLK_INT = 32'h396D_2E04, CLK_SYNC = 32'h8010_91C4, IF_A = 32'h7800_0000;

   logic clk_sys = 1'b0, reset = 1'b1, ref_tick = 1'b0, pfd_tick = 1'b0;
   logic ser_clk_pin, ser_data_pin, load_enable_pin;
   sfcr_pulse_t pfd_pulse = '0;
   sfcr_func_t function_control;
   sfcr_clock_t clock_ramp_config;
   logic [31:0] loaded_word;
   logic loaded_word_strobe, int_load_strobe, frac_load_strobe, modulator_reset, psk_enable, lock_detect;
   logic cp_three_state, rf_counter_load, modulator_disable, ramp_divider_select, fast_lock_divider_select;
   logic single_ramp_burst, power_down;
   logic [4:0] ramp_status;
   logic [11:0] second_timer_divider, second_timer_divider_alt;
   logic [3:0] test_mux_select;
   int n_mismatch = 0, comparisons = 0, cycles = 0, n_int = 0;

   sfcr_host_model host (.clk_sys, .ser_clk_pin, .ser_data_pin, .load_enable_pin);

   synth_function_clock_regs dut (.clk_sys, .reset, .ser_clk_pin, .ser_data_pin, .load_enable_pin, .ref_tick,
      .pfd_tick, .pfd_pulse, .function_control, .clock_ramp_config, .loaded_word, .loaded_word_strobe,
      .bleed_current_level(), .bleed_active(), .loss_of_lock_mode(), .int_load_strobe, .frac_load_strobe,
      .modulator_reset, .ramp_mode(), .ramp_enable(), .single_ramp_burst, .psk_enable, .fsk_enable(),
      .phase_adjust_enable(), .lock_detect, .pd_polarity(), .power_down, .cp_three_state, .rf_counter_reset(),
      .rf_counter_load, .modulator_disable, .ramp_status, .ramp_divider_select, .fast_lock_divider_select,
      .second_timer_divider, .second_timer_divider_alt, .test_mux_select);

   always #10 clk_sys = ~clk_sys;

   // ==========================
   // Tasks
   // ==========================
   task automatic summarize;
      if (n_mismatch == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize

   task automatic wait_load(input logic [31:0] w);
      for (int i = 0; i < 20 && loaded_word_strobe !== 1'b1; i++)
         @(negedge clk_sys);
      `CHK("strobe", 1'b1, loaded_word_strobe)
      `CHK("word", w, loaded_word)
   endtask : wait_load

   task automatic wr(input logic [31:0] w);
      host.send(w);
      wait_load(w);
   endtask : wr

   task automatic pulses(input int k, input logic [7:0] w);
      repeat (32 * k)
      begin
         @(negedge clk_sys);
         pfd_pulse = '{strobe: 1'b1, width_ns: w};
         @(negedge clk_sys);
         pfd_pulse.strobe = 1'b0;
      end
      @(negedge clk_sys);
   endtask : pulses

   task automatic pfd(input int k);
      repeat (k)
      begin
         @(negedge clk_sys);
         pfd_tick = 1'b1;
         @(negedge clk_sys);
         pfd_tick = 1'b0;
      end
      repeat (3) @(negedge clk_sys);
   endtask : pfd

   // ==========================
   // Monitors
   // ==========================
   always @(negedge clk_sys)
   begin
      cycles++;
      if (int_load_strobe === 1'b1)
         n_int++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         summarize();
      end
   end

   // ==========================
   // Sequence
   // ==========================
   initial
   begin
      repeat (4) @(negedge clk_sys);
      reset = 1'b0;
      @(negedge clk_sys);
      `CHK("func reset", FUNC_RESET, function_control)
      `CHK("clock reset", CLOCK_RESET, clock_ramp_config)
      wr(CLK_INT);
      `CHK("int mode", 1'b1, modulator_disable)
      `CHK("status", 5'h0B, ramp_status)
      `CHK("ramp div", 1'b1, ramp_divider_select)
      `CHK("fast div", 1'b0, fast_lock_divider_select)
      `CHK("timer div", 12'hA5C, second_timer_divider)
      wr(FUNC_A);
      `CHK("func", FUNC_A, function_control)
      `CHK("psk off", 1'b0, psk_enable)
      `CHK("burst", 1'b1, single_ramp_burst)
      `CHK("tristate", 1'b1, cp_three_state)
      wr(FUNC_B);
      wr(32'h1234_5675);
      `CHK("func kept", FUNC_B, function_control)
      `CHK("clock kept", CLK_INT, clock_ramp_config)
      n_int = 0;
      wr(IF_A);
      `CHK("frac load", 1'b1, frac_load_strobe)
      `CHK("sd reset", 1'b0, modulator_reset)
      `CHK("mux", 4'hF, test_mux_select)
      pfd(3);
      `CHK("int early", 0, n_int)
      pfd(1);
      `CHK("int aligned", 1, n_int)
      pulses(4, 8'h05);
      `CHK("lock early", 1'b0, lock_detect)
      pulses(1, 8'h05);
      `CHK("lock", 1'b1, lock_detect)
      pulses(1, 8'h16);
      `CHK("lock held", 1'b1, lock_detect)
      pulses(1, 8'h17);
      `CHK("lock lost", 1'b0, lock_detect)
      pulses(5, 8'h06);
      `CHK("fine limit", 1'b0, lock_detect)
      pulses(5, 8'h05);
      wr(IF_A);
      `CHK("write unlock", 1'b0, lock_detect)
      wr(FUNC_A);
      wr(IF_A);
      `CHK("sd reset on", 1'b1, modulator_reset)
      `CHK("int now", 1'b1, int_load_strobe)
      pulses(5, 8'h0D);
      `CHK("coarse limit", 1'b1, lock_detect)
      wr(FUNC_PD);
      `CHK("pd out", 1'b1, power_down)
      `CHK("pd load", 1'b1, rf_counter_load)
      `CHK("pd pump", 1'b1, cp_three_state)
      wr(CLK_SYNC);
      `CHK("pd unlock", 1'b0, lock_detect)
      `CHK("alt div", 12'h123, second_timer_divider_alt)
      `CHK("div kept", 12'hA5C, second_timer_divider)
      `CHK("fast sel", 1'b1, fast_lock_divider_select)
      `CHK("psk on", 1'b1, psk_enable)
      host.send(CLK_INT);
      repeat (5) @(negedge clk_sys);
      `CHK("wait ref", CLK_SYNC, clock_ramp_config)
      ref_tick = 1'b1;
      @(negedge clk_sys);
      ref_tick = 1'b0;
      wait_load(CLK_INT);
      summarize();
   end
endmodule : synth_function_clock_regs_test
